// File: pkg/i2c_dim_pkg.sv
// constants and types shared by both ends of the dimming link
package i2c_dim_pkg;

  // clock and derived timing
  localparam int CLK_HZ        = 100_000_000;
  localparam int PWM_HZ        = 1250;
  localparam int PWM_SLOTS     = 256;
  localparam int PWM_SLOT_CYC  = CLK_HZ / (PWM_HZ * PWM_SLOTS);
  localparam int DUTY_MIN      = 13;   // 5 percent of 256 slots
  localparam int DUTY_SPAN     = 243;  // slots added across levels 1..255
  localparam int LEVEL_SPAN    = 254;
  localparam int FADE_UNIT_MS  = 32;
  localparam int FADE_STEPS    = 256;
  localparam int FADE_STEP_CYC = FADE_UNIT_MS * (CLK_HZ / 1000) / FADE_STEPS;
  localparam int AUX_RETRY_S   = 2;
  localparam int AUX_RETRY_CYC = AUX_RETRY_S * CLK_HZ;
  localparam int I2C_HZ        = 100_000;
  localparam int QUARTER_CYC   = CLK_HZ / (4 * I2C_HZ);

  // field identifiers
  localparam logic [7:0] F_LEVEL    = 8'h00;
  localparam logic [7:0] F_STARTUP  = 8'h01;
  localparam logic [7:0] F_FADE     = 8'h02;
  localparam logic [7:0] F_OWN      = 8'h03;
  localparam logic [7:0] F_BCAST    = 8'h04;
  localparam logic [7:0] F_SUPPLY   = 8'h05;
  localparam logic [3:0] F_RECALL   = 4'h1;
  localparam logic [3:0] F_STORE    = 4'h2;
  localparam logic [7:0] F_REV_MAJ  = 8'hfd;
  localparam logic [7:0] F_REV_MIN  = 8'hfe;
  localparam logic [7:0] F_RESTORE  = 8'hff;

  // field reset values and limits
  localparam logic [7:0] LEVEL_RST   = 8'h00;
  localparam logic [7:0] STARTUP_RST = 8'hff;
  localparam logic [7:0] FADE_RST    = 8'h10;
  localparam logic [7:0] OWN_RST     = 8'h50;
  localparam logic [7:0] BCAST_RST   = 8'h77;
  localparam logic [7:0] SCENE_RST   = 8'h00;
  localparam logic [7:0] OWN_MIN     = 8'h01;
  localparam logic [7:0] REV_MAJ_VAL = 8'h02;  // arbitrary value
  localparam logic [7:0] REV_MIN_VAL = 8'h03;  // arbitrary value

  // controller register offsets and bits
  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_SLAVE  = 8'h04;
  localparam logic [7:0] R_FIELD  = 8'h08;
  localparam logic [7:0] R_WDATA  = 8'h0c;
  localparam logic [7:0] R_STATUS = 8'h10;
  localparam logic [7:0] R_RDATA  = 8'h14;
  localparam int CTRL_GO  = 0;
  localparam int CTRL_RD  = 1;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_FIELD, D_WDATA, D_SEND}
    dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_RDBYTE, H_STOP}
    host_state_t;

endpackage : i2c_dim_pkg

// File: pkg/i2c_link_if.sv
// two-wire link between the controller and the dimming device
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // open-drain wired-and with pull-ups
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport device (input scl, sda, output dev_sda_o, dev_sda_oe);
  modport host (input scl, sda,
                output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe);
endinterface : i2c_link_if
`default_nettype wire

// File: rtl/i2c_dim_device.sv
// dimming device: field-addressed two-wire slave, fader, pwm, aux retry
//
// What this block does
// - pwm near 1.25 kHz, 5 to 100 percent
// - field 0x00 sets live level, default 0
// - master computes level from percent formula
// - startup level field 0x01 applied at start
// - fade time is field 0x02 times 32 ms
// - own address field 0x03, msb restores 0x50
// - own address accepts 0x01 up to 0x7f
// - broadcast field 0x04, msb disables it
// - own and broadcast address act alike
// - master never reads via broadcast address
// - field 0x05 reads supply source type
// - sixteen scene slots of one level each
// - write to 0x2x stores scene slot
// - read of 0x1x recalls scene slot
// - fields 0xfd 0xfe return fixed revisions
// - write to 0xff restores all defaults
// - analog input below 0.5 v turns off
// - aux short removes power, retries every 2 s
// - source select open means two-wire control
`timescale 1ns/1ps
`default_nettype none
module i2c_dim_device
  import i2c_dim_pkg::*;
#(
  parameter int FADE_TICK_CYC = FADE_STEP_CYC,
  parameter int RETRY_CYC     = AUX_RETRY_CYC
) (
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // two-wire link
  i2c_link_if.device      link,
  // analog and board inputs
  input  wire logic       control_source_select,
  input  wire logic [7:0] dim_code,
  input  wire logic       dim_below_min,
  input  wire logic [7:0] supply_type,
  input  wire logic       aux_short,
  // drive outputs
  output logic            led_pwm,
  output logic            aux_power_en
);

  logic [20:0] sync1;
  logic [20:0] sync2;
  logic        scl_s;
  logic        sda_s;
  logic        sel_s;
  logic        low_s;
  logic        short_s;
  logic [7:0]  dim_s;
  logic [7:0]  sup_s;
  logic        scl_d;
  logic        sda_d;
  logic        start;
  logic        stop;
  logic        scl_rise;
  logic        scl_fall;
  dev_state_t  state;
  logic [2:0]  bits;
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [7:0]  field;
  logic [7:0]  byte_in;
  logic        ack_pend;
  logic        in_ack;
  logic        sda_oe;
  logic        wr_stb;
  logic        rcl_stb;
  logic [7:0]  wr_data;
  logic        hit;
  logic [7:0]  rd_val;
  logic [7:0]  led_level_now;
  logic [7:0]  startup_level;
  logic [7:0]  fade_duration;
  logic [7:0]  own_slave_address;
  logic [7:0]  broadcast_slave_address;
  logic [7:0]  scene [16];
  logic        booted;
  logic [7:0]  target;
  logic [7:0]  level;
  logic [13:0] tick_cnt;
  logic [7:0]  fade_step_count;
  logic [8:0]  slot_cnt;
  logic [7:0]  phase;
  logic [15:0] prod;
  logic [8:0]  duty;
  logic [27:0] retry_cnt;

  // two-flop synchronisers for every outside input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 21'h180000;
      sync2 <= 21'h180000;
    end else begin
      sync1 <= {link.scl, link.sda, control_source_select, dim_below_min,
                aux_short, dim_code, supply_type};
      sync2 <= sync1;
    end
  end

  assign scl_s   = sync2[20];
  assign sda_s   = sync2[19];
  assign sel_s   = sync2[18];
  assign low_s   = sync2[17];
  assign short_s = sync2[16];
  assign dim_s   = sync2[15:8];
  assign sup_s   = sync2[7:0];

  // line history for edge and condition detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign start    = scl_s && scl_d && sda_d && !sda_s;
  assign stop     = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign byte_in  = {sh[6:0], sda_s};
  // own or enabled broadcast address, both treated alike
  assign hit = (byte_in[7:1] == own_slave_address[6:0]) ||
               (!broadcast_slave_address[7] &&
                byte_in[7:1] == broadcast_slave_address[6:0]);

  // slave byte engine: address, field, data or one read byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state    <= D_IDLE;
      bits     <= 3'h0;
      sh       <= 8'h00;
      tx       <= 8'hff;
      field    <= 8'h00;
      ack_pend <= 1'b0;
      in_ack   <= 1'b0;
      sda_oe   <= 1'b0;
      wr_stb   <= 1'b0;
      rcl_stb  <= 1'b0;
      wr_data  <= 8'h00;
    end else begin
      wr_stb  <= 1'b0;
      rcl_stb <= 1'b0;
      if (start) begin
        state    <= D_ADDR;
        bits     <= 3'h0;
        ack_pend <= 1'b0;
        in_ack   <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (stop) begin
        state    <= D_IDLE;
        ack_pend <= 1'b0;
        in_ack   <= 1'b0;
        sda_oe   <= 1'b0;
      end else if (scl_rise && !in_ack && state != D_IDLE) begin
        bits <= bits + 3'h1;
        sh   <= byte_in;
        tx   <= {tx[6:0], 1'b1};
        if (bits == 3'h7) begin
          unique case (state)
            D_ADDR: begin
              if (hit) begin
                ack_pend <= 1'b1;
                if (byte_in[0]) begin
                  state   <= D_SEND;
                  tx      <= rd_val;
                  rcl_stb <= (field[7:4] == F_RECALL);
                end else begin
                  state <= D_FIELD;
                end
              end else begin
                state <= D_IDLE;
              end
            end
            D_FIELD: begin
              field    <= byte_in;
              ack_pend <= 1'b1;
              state    <= D_WDATA;
            end
            D_WDATA: begin
              wr_data  <= byte_in;
              wr_stb   <= 1'b1;
              ack_pend <= 1'b1;
            end
            D_SEND: state <= D_IDLE;
            D_IDLE: state <= D_IDLE;
          endcase
        end
      end else if (scl_fall) begin
        if (ack_pend) begin
          sda_oe   <= 1'b1;                          // drive ack low
          ack_pend <= 1'b0;
          in_ack   <= 1'b1;
        end else begin
          in_ack <= 1'b0;
          sda_oe <= (state == D_SEND) && !tx[7];
        end
      end
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe;

  // read data for the current field
  always_comb begin
    rd_val = 8'h00;
    if (field[7:4] == F_RECALL) begin
      rd_val = scene[field[3:0]];
    end else begin
      unique case (field)
        F_LEVEL:   rd_val = led_level_now;
        F_STARTUP: rd_val = startup_level;
        F_FADE:    rd_val = fade_duration;
        F_OWN:     rd_val = own_slave_address;
        F_BCAST:   rd_val = broadcast_slave_address;
        F_SUPPLY:  rd_val = sup_s;
        F_REV_MAJ: rd_val = REV_MAJ_VAL;
        F_REV_MIN: rd_val = REV_MIN_VAL;
        default:   rd_val = 8'h00;
      endcase
    end
  end

  // field storage, scene slots, restore and recall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_level_now           <= LEVEL_RST;
      startup_level           <= STARTUP_RST;
      fade_duration           <= FADE_RST;
      own_slave_address       <= OWN_RST;
      broadcast_slave_address <= BCAST_RST;
      booted                  <= 1'b0;
      for (int i = 0; i < 16; i++) begin
        scene[i] <= SCENE_RST;
      end
    end else begin
      if (!booted) begin
        booted        <= 1'b1;
        led_level_now <= startup_level;
      end
      if (rcl_stb) begin
        led_level_now <= scene[field[3:0]];
      end
      if (wr_stb) begin
        if (field == F_RESTORE) begin
          led_level_now           <= LEVEL_RST;
          startup_level           <= STARTUP_RST;
          fade_duration           <= FADE_RST;
          own_slave_address       <= OWN_RST;
          broadcast_slave_address <= BCAST_RST;
          for (int i = 0; i < 16; i++) begin
            scene[i] <= SCENE_RST;
          end
        end else if (field[7:4] == F_STORE) begin
          scene[field[3:0]] <= wr_data;
        end else if (field == F_LEVEL) begin
          led_level_now <= wr_data;
        end else if (field == F_STARTUP) begin
          startup_level <= wr_data;
        end else if (field == F_FADE) begin
          fade_duration <= wr_data;
        end else if (field == F_OWN) begin
          if (wr_data[7]) begin
            own_slave_address <= OWN_RST;
          end else if (wr_data >= OWN_MIN) begin
            own_slave_address <= wr_data;
          end
        end else if (field == F_BCAST) begin
          broadcast_slave_address <= wr_data;
        end
      end
    end
  end

  // brightness source: link field or analog input
  always_comb begin
    if (sel_s) begin
      target = led_level_now;
    end else if (low_s) begin
      target = 8'h00;
    end else if (dim_s == 8'h00) begin
      target = 8'h01;
    end else begin
      target = dim_s;
    end
  end

  // fader: one level step per fade_duration ticks of 125 us
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt        <= 14'h0000;
      fade_step_count <= 8'h00;
      level           <= 8'h00;
    end else if (fade_duration == 8'h00) begin
      level           <= target;
      tick_cnt        <= 14'h0000;
      fade_step_count <= 8'h00;
    end else if (tick_cnt == 14'(FADE_TICK_CYC - 1)) begin
      tick_cnt <= 14'h0000;
      if (fade_step_count + 8'h01 >= fade_duration) begin
        fade_step_count <= 8'h00;
        if (level < target) begin
          level <= level + 8'h01;
        end else if (level > target) begin
          level <= level - 8'h01;
        end
      end else begin
        fade_step_count <= fade_step_count + 8'h01;
      end
    end else begin
      tick_cnt <= tick_cnt + 14'h0001;
    end
  end

  // duty in 256 slots: level 1 gives 5 percent, 255 gives full
  assign prod = 16'(level - 8'h01) * 16'(DUTY_SPAN);
  assign duty = 9'(DUTY_MIN) + 9'(prod / 16'(LEVEL_SPAN));

  // pwm generator, period 256 slots
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_cnt <= 9'h000;
      phase    <= 8'h00;
      led_pwm  <= 1'b0;
    end else begin
      if (slot_cnt == 9'(PWM_SLOT_CYC - 1)) begin
        slot_cnt <= 9'h000;
        phase    <= phase + 8'h01;
      end else begin
        slot_cnt <= slot_cnt + 9'h001;
      end
      led_pwm <= (level != 8'h00) && ({1'b0, phase} < duty);
    end
  end

  // aux short: drop power, retry after the retry period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aux_power_en <= 1'b1;
      retry_cnt    <= 28'h0000000;
    end else if (aux_power_en) begin
      retry_cnt <= 28'h0000000;
      if (short_s) begin
        aux_power_en <= 1'b0;
      end
    end else if (retry_cnt == 28'(RETRY_CYC - 1)) begin
      aux_power_en <= 1'b1;
      retry_cnt    <= 28'h0000000;
    end else begin
      retry_cnt <= retry_cnt + 28'h0000001;
    end
  end

endmodule : i2c_dim_device
`default_nettype wire

// File: rtl/i2c_dim_host.sv
// controller end: ahb-lite registers driving a two-wire master
`timescale 1ns/1ps
`default_nettype none
module i2c_dim_host
  import i2c_dim_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // two-wire link
  i2c_link_if.host         link
);

  logic        ph_wr;
  logic [7:0]  ph_addr;
  logic        go_stb;
  logic        acc;
  logic [6:0]  slave;
  logic [7:0]  field_id;
  logic [7:0]  wdata;
  logic        rd_mode;
  logic        busy;
  logic        nack;
  logic [7:0]  rdata;
  logic [1:0]  sda_sync;
  host_state_t hst;
  logic [7:0]  qcnt;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic [2:0]  op;
  logic [7:0]  sh;
  logic        scl_oe;
  logic        sda_oe;

  // transfer sequence: write ends at op 4, read uses a restart
  function automatic host_state_t elem(input logic [2:0] o,
                                       input logic rd);
    host_state_t e;
    e = H_STOP;
    unique case (o)
      3'h0:    e = H_START;
      3'h1:    e = H_BYTE;
      3'h2:    e = H_BYTE;
      3'h3:    e = rd ? H_START : H_BYTE;
      3'h4:    e = rd ? H_BYTE : H_STOP;
      3'h5:    e = rd ? H_RDBYTE : H_STOP;
      default: e = H_STOP;
    endcase
    return e;
  endfunction : elem

  // byte sent for each element
  function automatic logic [7:0] obyte(input logic [2:0] o,
                                       input logic rd);
    logic [7:0] b;
    b = wdata;
    if (o == 3'h1) begin
      b = {slave, 1'b0};
    end else if (o == 3'h4) begin
      b = {slave, 1'b1};
    end else if (o == 3'h2) begin
      b = field_id;
    end
    return b;
  endfunction : obyte

  assign acc    = hsel && htrans[1] && hready;
  assign go_stb = ph_wr && ph_addr == R_CTRL && hwdata[CTRL_GO] && !busy;

  // ahb address phase capture and zero-wait read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr     <= 1'b0;
      ph_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ph_wr     <= acc && hwrite;
      ph_addr   <= haddr[7:0];
      hrdata    <= 32'h00000000;
      if (acc && !hwrite) begin
        unique case (haddr[7:0])
          R_CTRL:   hrdata <= {30'h0, rd_mode, 1'b0};
          R_SLAVE:  hrdata <= {25'h0, slave};
          R_FIELD:  hrdata <= {24'h0, field_id};
          R_WDATA:  hrdata <= {24'h0, wdata};
          R_STATUS: hrdata <= {30'h0, nack, busy};
          R_RDATA:  hrdata <= {24'h0, rdata};
          default:  hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // command registers, frozen while a transfer runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slave    <= 7'h50;
      field_id <= 8'h00;
      wdata    <= 8'h00;
      rd_mode  <= 1'b0;
    end else if (ph_wr && !busy) begin
      unique case (ph_addr)
        R_CTRL:  rd_mode  <= hwdata[CTRL_RD];
        R_SLAVE: slave    <= hwdata[6:0];
        R_FIELD: field_id <= hwdata[7:0];
        R_WDATA: wdata    <= hwdata[7:0];
        default: rd_mode  <= rd_mode;
      endcase
    end
  end

  // data line synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_sync <= 2'b11;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end

  // bit engine: four quarters per bit, start, byte and stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst    <= H_IDLE;
      qcnt   <= 8'h00;
      q      <= 2'h0;
      bitn   <= 4'h0;
      op     <= 3'h0;
      sh     <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      busy   <= 1'b0;
      nack   <= 1'b0;
      rdata  <= 8'h00;
    end else if (hst == H_IDLE) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      if (go_stb) begin
        busy <= 1'b1;
        nack <= 1'b0;
        op   <= 3'h0;
        q    <= 2'h0;
        qcnt <= 8'h00;
        hst  <= H_START;
      end
    end else if (qcnt != 8'(QUARTER_CYC - 1)) begin
      qcnt <= qcnt + 8'h01;
    end else begin
      qcnt <= 8'h00;
      q    <= q + 2'h1;
      unique case (q)
        2'h0: begin
          scl_oe <= 1'b1;
          if (hst == H_START) begin
            sda_oe <= 1'b0;
          end else if (hst == H_STOP) begin
            sda_oe <= 1'b1;
          end else begin
            sda_oe <= (hst == H_BYTE) && (bitn < 4'h8) && !sh[7];
          end
        end
        2'h1: scl_oe <= 1'b0;
        2'h2: begin
          if (hst == H_START) begin
            sda_oe <= 1'b1;
          end else if (hst == H_STOP) begin
            sda_oe <= 1'b0;
          end else if (bitn < 4'h8) begin
            sh <= {sh[6:0], sda_sync[1]};
          end else if (hst == H_BYTE) begin
            nack <= sda_sync[1];
          end else begin
            rdata <= sh;
          end
        end
        2'h3: begin
          if (hst == H_STOP) begin
            busy <= 1'b0;
            hst  <= H_IDLE;
          end else begin
            scl_oe <= 1'b1;
            bitn   <= bitn + 4'h1;
            if (hst == H_START || bitn == 4'h8) begin
              bitn <= 4'h0;
              if (nack) begin
                hst <= H_STOP;
                op  <= 3'h7;
              end else begin
                op  <= op + 3'h1;
                hst <= elem(op + 3'h1, rd_mode);
                sh  <= obyte(op + 3'h1, rd_mode);
              end
            end
          end
        end
      endcase
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = scl_oe;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_oe;

endmodule : i2c_dim_host
`default_nettype wire

// File: test/i2c_led_dimming_controller_properties.sv
// link timing checks on the shared two-wire lines
`timescale 1ns/1ps
`default_nettype none
module i2c_led_dimming_controller_properties (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // link signals
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // all checks share the one bus clock
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  dev_sda_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device sda moved with scl high");
  scl_low_min_a: assert property ($rose(host_scl_oe) |-> host_scl_oe [*8])
    else $error("scl low phase too short");
  scl_low_max_a: assert property
    ($rose(host_scl_oe) |-> ##[1:600] !host_scl_oe)
    else $error("scl low phase too long");
  scl_high_min_a: assert property ($fell(host_scl_oe) |-> !host_scl_oe [*8])
    else $error("scl high phase too short");
  host_frames_a: assert property
    (scl && $past(scl) && $changed(sda) |-> $changed(host_sda_oe))
    else $error("framing edge not made by host");
  start_clock_a: assert property
    ($fell(sda) && scl |-> ##[1:300] !scl)
    else $error("no clock after start");
  stop_idle_a: assert property ($rose(sda) && scl |-> scl [*8])
    else $error("scl not idle after stop");
  ack_clock_a: assert property ($rose(dev_sda_oe) |-> ##[1:600] scl)
    else $error("no clock while device drives");
  // main link events
  cover property ($fell(sda) && scl);
  cover property ($rose(dev_sda_oe));
  cover property ($rose(sda) && scl);
endmodule : i2c_led_dimming_controller_properties
`default_nettype wire

// File: test/i2c_led_dimming_controller_test.sv
// self-checking bench for both ends of the dimming link
`timescale 1ns/1ps
`default_nettype none
module i2c_led_dimming_controller_test
  import i2c_dim_pkg::*;
;
  typedef struct packed {
    logic       rd;
    logic [6:0] sa;
    logic [7:0] f;
    logic [7:0] d;
    logic       nack;
    logic [7:0] q;
  } row_t;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        led_pwm, aux_power_en, aux_short;
  logic        src_sel, dim_low;
  logic [31:0] haddr, hwdata, hrdata, st, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fail_count, checks;
  // level for 50 percent, worked out the way a master must
  localparam logic [7:0] HALF_LEVEL = 8'(45 * 254 / 95 + 1);
  // broadcast write only, own-address read back, foreign address refused
  row_t rows [3] = '{
    '{1'b0, BCAST_RST[6:0], F_LEVEL, HALF_LEVEL, 1'b0, 8'h00},
    '{1'b1, OWN_RST[6:0], F_LEVEL, 8'h00, 1'b0, HALF_LEVEL},
    '{1'b0, 7'h33, F_LEVEL, 8'h11, 1'b1, 8'h00}};
  i2c_link_if link_bus ();
  i2c_dim_device #(.FADE_TICK_CYC(4), .RETRY_CYC(50)) i_i2c_dim_device (
    .hclk(hclk), .hresetn(hresetn), .link(link_bus.device),
    .control_source_select(src_sel), .dim_code(8'h40),
    .dim_below_min(dim_low), .supply_type(8'h3c), .aux_short(aux_short),
    .led_pwm(led_pwm), .aux_power_en(aux_power_en));
  i2c_dim_host i_i2c_dim_host (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .link(link_bus.host));
  i2c_led_dimming_controller_properties
    i_i2c_led_dimming_controller_properties (
    .hclk(hclk), .hresetn(hresetn), .host_scl_oe(link_bus.host_scl_oe),
    .host_sda_oe(link_bus.host_sda_oe), .dev_sda_oe(link_bus.dev_sda_oe),
    .scl(link_bus.scl), .sda(link_bus.sda));
  // free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // verdict and end of run
  task automatic print_verdict;
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  // compare one value
  task automatic check_value(input logic [31:0] got,
                             input logic [31:0] want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check_value
  // one single ahb-lite word transfer, entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : ahb
  // one link transfer through the controller registers
  task automatic xfer(input logic rd, input logic [6:0] sa,
                      input logic [7:0] f, input logic [7:0] d,
                      output logic [31:0] s, output logic [31:0] r);
    int n;
    logic [31:0] x;
    ahb(1'b1, R_SLAVE, {25'h0, sa}, x);
    ahb(1'b1, R_FIELD, {24'h0, f}, x);
    ahb(1'b1, R_WDATA, {24'h0, d}, x);
    ahb(1'b1, R_CTRL, {30'h0, rd, 1'b1}, x);
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 60000) begin
      ahb(1'b0, R_STATUS, 32'h0, s);
      n++;
    end
    if (n >= 60000) begin
      fail_count++;
    end
    ahb(1'b0, R_RDATA, 32'h0, r);
  endtask : xfer
  // watchdog against a hung transfer: the tests need about 80k cycles
  initial begin
    repeat (95000) @(posedge hclk);
    fail_count++;
    print_verdict();
  end
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, aux_short, htrans, hsize} = '0;
    {haddr, hwdata} = '0;
    src_sel = 1'b0;
    dim_low = 1'b1;
    repeat (2) @(posedge hclk);
    check_value({31'h0, aux_power_en}, 32'h1);
    check_value({31'h0, led_pwm}, 32'h0);
    hresetn <= 1'b1;
    // analog source: off below the minimum, lit once it is above
    repeat (100) @(posedge hclk);
    check_value({31'h0, led_pwm}, 32'h0);
    dim_low <= 1'b0;
    repeat (100) @(posedge hclk);
    check_value({31'h0, led_pwm}, 32'h1);
    src_sel <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, R_SLAVE, 32'h0, q);
    check_value(q, {24'h0, OWN_RST});
    ahb(1'b0, 8'h40, 32'h0, q);
    check_value(q, 32'h0);
    foreach (rows[i]) begin
      xfer(rows[i].rd, rows[i].sa, rows[i].f, rows[i].d, st, q);
      check_value({31'h0, st[1]}, {31'h0, rows[i].nack});
      if (rows[i].rd) begin
        check_value({24'h0, q[7:0]}, {24'h0, rows[i].q});
      end
    end
    // short on aux output, then removed before the retry
    aux_short <= 1'b1;
    repeat (10) @(posedge hclk);
    check_value({31'h0, aux_power_en}, 32'h0);
    aux_short <= 1'b0;
    repeat (70) @(posedge hclk);
    check_value({31'h0, aux_power_en}, 32'h1);
    check_value({31'h0, hresp}, 32'h0);
    print_verdict();
  end
endmodule : i2c_led_dimming_controller_test
`default_nettype wire
